//--- pkg/tacw_map.vh
`ifndef TACW_MAP_VH
`define TACW_MAP_VH

// Command word field positions, most significant bit first on the wire
`define TACW_BIT_START 7
`define TACW_BIT_CH_HI 6
`define TACW_BIT_CH_LO 4
`define TACW_BIT_RES 3
`define TACW_BIT_REF 2
`define TACW_BIT_PWR_HI 1
`define TACW_BIT_PWR_LO 0
`define TACW_WORD_BITS 4'h8

// Power-up values of the power bits
`define TACW_RST_PWR_HI 1'h1
`define TACW_RST_PWR_LO 1'h0
// Power-up values of the remaining fields (no conversion configured)
`define TACW_RST_CHAN 3'h0
`define TACW_RST_RES 1'h0
`define TACW_RST_REF 1'h1

// Channel codes
`define TACW_CH_XPOS 3'h1
`define TACW_CH_AUX1 3'h2
`define TACW_CH_YPOS 3'h5
`define TACW_CH_AUX2 3'h6

// Multiplexer selection codes
`define TACW_MUX_NONE 3'h0
`define TACW_MUX_XPOS 3'h1
`define TACW_MUX_YPOS 3'h2
`define TACW_MUX_AUX1 3'h3
`define TACW_MUX_AUX2 3'h4

// Reference routing codes
`define TACW_REFSEL_PIN 2'h0
`define TACW_REFSEL_YDRV 2'h1
`define TACW_REFSEL_XDRV 2'h2

// Serial clock counts, counted from the word's last rising edge
`define TACW_GAP_12BIT 5'h07
`define TACW_GAP_8BIT 5'h03
// Falling edges after the start marker for power up and power down
`define TACW_FALL_PWR_UP 5'h04
`define TACW_FALL_PWR_DOWN 5'h14

`endif

//--- logic/tacw_sync.v
`timescale 1ns/1ps
`default_nettype none

module tacw_sync (
    input wire clock_in,
    input wire arst_n_in,
    input wire async_in,
    output reg sync_out
);

    reg stage_one;

    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stage_one <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end

endmodule // tacw_sync

`default_nettype wire

//--- logic/tacw_control_word.v
// How it works
// [R1] Host starts every command with a high marker bit.
// [R2] Serial data is ignored until a start marker is seen.
// [R3] First high bit sampled on serial data is the start marker.
// [R4] Fields arrive MSB first: marker, channel, resolution, reference, power bits.
// [R5] Next command accepted only after 15 or 11 serial clocks per resolution.
// [R6] Channel and reference bits set mux, panel drivers and reference routing.
// [R7] 001 X-plus with Y drivers, 101 Y-plus with X drivers, 010/110 auxiliaries.
// [R8] Resolution bit zero means 12-bit, one means 8-bit conversion.
// [R9] Reference bit one is single-ended, zero is differential.
// [R10] Differential reference comes from the active panel driver nodes.
// [R11] Single-ended reference is the reference pin against ground.
// [R12] Host uses differential mode only for X and Y positions.
// [R13] At power-up low power bit is zero, high power bit is one.
// [R14] Code 00 powers down after conversion; pen interrupt and Y-minus stay on.
// [R15] Leaving power-down at conversion start restores full power at once.
// [R16] Code 01 powers down like 00 but pen interrupt off, Y-minus open.
// [R17] Code 10 stays powered with pen interrupt enabled.
// [R18] Code 11 stays powered with pen interrupt disabled.
// [R19] Power up on fourth falling edge after marker, down on twentieth.
// [R20] Command bits sampled on rising serial clock edges, only after a marker.
// [R21] Latched settings hold until a later valid command overwrites them.
`timescale 1ns/1ps
`default_nettype none
`include "tacw_map.vh"

module tacw_control_word (
    input wire clock_in,
    input wire arst_n_in,
    input wire host_serial_clock_in,
    input wire serial_data_in,
    output reg [2:0] channel_select_out,
    output reg resolution_8bit_out,
    output reg reference_mode_select_out,
    output reg power_bit_high_out,
    output reg power_bit_low_out,
    output reg [2:0] mux_select_out,
    output reg x_drivers_on_out,
    output reg y_drivers_on_out,
    output reg y_minus_on_out,
    output reg [1:0] reference_route_out,
    output reg channel_invalid_out,
    output reg touch_detect_interrupt_enable_out,
    output reg converter_powered_out,
    output reg word_valid_out
);

    localparam ST_HUNT = 3'b001;
    localparam ST_SHIFT = 3'b010;
    localparam ST_GAP = 3'b100;

    wire sclk_sync;
    wire data_sync;
    reg sclk_prev;
    reg [2:0] state;
    reg [3:0] bit_count;
    reg [6:0] shift;
    reg [4:0] gap_count;
    reg [4:0] fall_count;
    reg fall_active;

    tacw_sync u_sync_sclk (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .async_in(host_serial_clock_in),
        .sync_out(sclk_sync)
    );

    tacw_sync u_sync_data (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .async_in(serial_data_in),
        .sync_out(data_sync)
    );

    wire sclk_rise = sclk_sync & ~sclk_prev;
    wire sclk_fall = ~sclk_sync & sclk_prev;
    // Assembled on the eighth rise: six held bits plus the one on the wire now
    wire [7:0] word_full = {1'b1, shift[5:0], data_sync};
    wire last_bit = (state == ST_SHIFT) && sclk_rise && (bit_count == 4'h7);

    // Serial receive: hunt for marker, shift seven field bits, then wait out the gap
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sclk_prev <= 1'b0;
            state <= ST_HUNT;
            bit_count <= 4'h0;
            shift <= 7'h00;
            gap_count <= 5'h00;
            word_valid_out <= 1'b0;
        end else begin
            sclk_prev <= sclk_sync;
            word_valid_out <= 1'b0;
            case (state)
                ST_HUNT: begin
                    if (sclk_rise && data_sync) begin // [R2] [R3] [R20]
                        state <= ST_SHIFT;
                        bit_count <= 4'h1;
                        shift <= 7'h00;
                    end
                end
                ST_SHIFT: begin
                    if (sclk_rise) begin
                        shift <= {shift[5:0], data_sync}; // [R4] [R20]
                        bit_count <= bit_count + 4'h1;
                        if (bit_count == 4'h7) begin
                            word_valid_out <= 1'b1;
                            state <= ST_GAP;
                            // Gap depends on the resolution just received
                            gap_count <= 5'h00;
                        end
                    end
                end
                ST_GAP: begin
                    // Markers during the gap belong to conversion clocking and are not seen
                    if (sclk_rise) begin
                        gap_count <= gap_count + 5'h01;
                        if (gap_count + 5'h01 >= (resolution_8bit_out ? `TACW_GAP_8BIT : `TACW_GAP_12BIT)) begin // [R5]
                            state <= ST_HUNT;
                        end
                    end
                end
                default: begin
                    state <= ST_HUNT;
                end
            endcase
        end
    end

    // Latched command fields; change only on a completed word
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            channel_select_out <= `TACW_RST_CHAN;
            resolution_8bit_out <= `TACW_RST_RES;
            reference_mode_select_out <= `TACW_RST_REF;
            power_bit_high_out <= `TACW_RST_PWR_HI; // [R13]
            power_bit_low_out <= `TACW_RST_PWR_LO; // [R13]
        end else if (last_bit) begin // [R21]
            channel_select_out <= word_full[`TACW_BIT_CH_HI:`TACW_BIT_CH_LO]; // [R4]
            resolution_8bit_out <= word_full[`TACW_BIT_RES]; // [R8]
            reference_mode_select_out <= word_full[`TACW_BIT_REF]; // [R9]
            power_bit_high_out <= word_full[`TACW_BIT_PWR_HI]; // [R4]
            power_bit_low_out <= word_full[`TACW_BIT_PWR_LO]; // [R4]
        end
    end

    // Falling edge count from the marker for power sequencing
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fall_count <= 5'h00;
            fall_active <= 1'b0;
        end else if (state == ST_HUNT && sclk_rise && data_sync) begin
            fall_count <= 5'h00;
            fall_active <= 1'b1;
        end else if (fall_active && sclk_fall) begin
            fall_count <= fall_count + 5'h01;
            if (fall_count + 5'h01 == `TACW_FALL_PWR_DOWN) begin
                fall_active <= 1'b0;
            end
        end
    end

    // Power state: modes 00 and 01 sleep between conversions
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            converter_powered_out <= 1'b1;
        end else begin
            if (power_bit_high_out) begin
                converter_powered_out <= 1'b1; // [R17] [R18]
            end else if (fall_active && sclk_fall && fall_count + 5'h01 == `TACW_FALL_PWR_UP) begin
                converter_powered_out <= 1'b1; // [R15] [R19]
            end else if (fall_active && sclk_fall && fall_count + 5'h01 == `TACW_FALL_PWR_DOWN) begin
                converter_powered_out <= 1'b0; // [R14] [R19]
            end
        end
    end

    // Decode channel, drivers, reference routing and pen interrupt enable
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mux_select_out <= `TACW_MUX_NONE;
            x_drivers_on_out <= 1'b0;
            y_drivers_on_out <= 1'b0;
            y_minus_on_out <= 1'b1;
            reference_route_out <= `TACW_REFSEL_PIN;
            channel_invalid_out <= 1'b0;
            touch_detect_interrupt_enable_out <= 1'b1;
        end else begin
            mux_select_out <= `TACW_MUX_NONE;
            x_drivers_on_out <= 1'b0;
            y_drivers_on_out <= 1'b0;
            reference_route_out <= `TACW_REFSEL_PIN; // [R11]
            channel_invalid_out <= 1'b0;
            if (channel_select_out == `TACW_CH_XPOS) begin // [R6] [R7]
                mux_select_out <= `TACW_MUX_XPOS;
                y_drivers_on_out <= 1'b1;
                if (!reference_mode_select_out) begin
                    reference_route_out <= `TACW_REFSEL_YDRV; // [R10]
                end
            end else if (channel_select_out == `TACW_CH_YPOS) begin // [R6] [R7]
                mux_select_out <= `TACW_MUX_YPOS;
                x_drivers_on_out <= 1'b1;
                if (!reference_mode_select_out) begin
                    reference_route_out <= `TACW_REFSEL_XDRV; // [R10]
                end
            end else if (channel_select_out == `TACW_CH_AUX1) begin // [R7]
                mux_select_out <= `TACW_MUX_AUX1;
                channel_invalid_out <= ~reference_mode_select_out; // [R12]
            end else if (channel_select_out == `TACW_CH_AUX2) begin // [R7]
                mux_select_out <= `TACW_MUX_AUX2;
                channel_invalid_out <= ~reference_mode_select_out; // [R12]
            end else begin
                channel_invalid_out <= 1'b1; // [R7]
            end
            // Pen interrupt enable is the inverse of the low power bit in every mode
            touch_detect_interrupt_enable_out <= ~power_bit_low_out; // [R14] [R16] [R17] [R18]
            // Y-minus closes while asleep only in mode 00
            // Read the latched bits directly so it settles with the pen enable
            y_minus_on_out <= ~(~power_bit_high_out & power_bit_low_out); // [R14] [R16]
        end
    end

endmodule // tacw_control_word

`default_nettype wire

//--- logic/tacw_unused_placeholder_never.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- tb/tacw_host.sv
`timescale 1ns/1ps
`default_nettype none
module tacw_host (
    input wire logic go_in,
    input wire logic [31:0] bits_in,
    input wire logic [5:0] len_in,
    output logic sclk_out,
    output logic sdata_out,
    output logic done_out
);
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        done_out = 1'b0;
    end
    // Clock stands low between frames; data idles low so no false marker
    always @(posedge go_in) begin
        done_out = 1'b0;
        for (int i = 0; i < len_in; i++) begin
            sdata_out = bits_in[31 - i];
            #80 sclk_out = 1'b1;
            #80 sclk_out = 1'b0;
        end
        sdata_out = 1'b0;
        done_out = 1'b1;
    end
endmodule // tacw_host
`default_nettype wire

//--- tb/tacw_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "tacw_map.vh"
module tacw_monitor (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic host_serial_clock_in,
    input wire logic serial_data_in,
    input wire logic [2:0] channel_select_out,
    input wire logic resolution_8bit_out,
    input wire logic reference_mode_select_out,
    input wire logic power_bit_high_out,
    input wire logic power_bit_low_out,
    input wire logic [2:0] mux_select_out,
    input wire logic x_drivers_on_out,
    input wire logic y_drivers_on_out,
    input wire logic y_minus_on_out,
    input wire logic [1:0] reference_route_out,
    input wire logic channel_invalid_out,
    input wire logic touch_detect_interrupt_enable_out,
    input wire logic converter_powered_out,
    input wire logic word_valid_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    chk_pen_code: assert property (!word_valid_out |-> touch_detect_interrupt_enable_out == !power_bit_low_out)
        else $error("pen enable wrong");
    chk_yminus_code: assert property (!word_valid_out |-> y_minus_on_out == !(!power_bit_high_out && power_bit_low_out))
        else $error("y minus wrong");
    chk_fields_hold: assert property ($changed({channel_select_out, resolution_8bit_out, reference_mode_select_out,
        power_bit_high_out, power_bit_low_out}) |-> word_valid_out)
        else $error("fields changed");
    chk_valid_pulse: assert property (word_valid_out |=> !word_valid_out)
        else $error("valid too long");
    chk_xpos_decode: assert property (!word_valid_out && channel_select_out == `TACW_CH_XPOS |->
        mux_select_out == `TACW_MUX_XPOS && y_drivers_on_out && !x_drivers_on_out)
        else $error("x decode wrong");
    chk_route_single: assert property (!word_valid_out && reference_mode_select_out |->
        reference_route_out == `TACW_REFSEL_PIN)
        else $error("route wrong");
    chk_route_diff: assert property (!word_valid_out && !reference_mode_select_out &&
        channel_select_out == `TACW_CH_YPOS |-> reference_route_out == `TACW_REFSEL_XDRV)
        else $error("diff route wrong");
    chk_pwr_hold: assert property (power_bit_high_out && $past(power_bit_high_out, 2) |-> converter_powered_out)
        else $error("not powered");
    cover property (word_valid_out);
    cover property ($fell(converter_powered_out));
    cover property (channel_invalid_out && channel_select_out == 3'h3);
endmodule // tacw_monitor
bind tacw_control_word tacw_monitor MON (.*);
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic go = 1'b0;
    logic [31:0] bits = 32'h0;
    logic [5:0] len = 6'h18;
    wire sclk, sdata, done, res, refm, ph, pl, xd, yd, ym, inv, pen, pw, wv;
    wire [2:0] ch, mux;
    wire [1:0] route;
    wire [17:0] state = {ch, res, refm, ph, pl, mux, xd, yd, route, inv, ym, pen, pw};
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    logic [17:0] prev;
    // Differential reference only on the X and Y rows
    logic [15:0] rows [6] = '{16'h9628, 16'h982A, 16'hD354, 16'hAD60, 16'hE680, 16'hB601};
    always #5 clock_in = ~clock_in;
    tacw_host HOST (.go_in(go), .bits_in(bits), .len_in(len), .sclk_out(sclk), .sdata_out(sdata), .done_out(done));
    tacw_control_word DUT (.clock_in(clock_in), .arst_n_in(arst_n_in), .host_serial_clock_in(sclk),
        .serial_data_in(sdata), .channel_select_out(ch), .resolution_8bit_out(res),
        .reference_mode_select_out(refm), .power_bit_high_out(ph), .power_bit_low_out(pl),
        .mux_select_out(mux), .x_drivers_on_out(xd), .y_drivers_on_out(yd), .y_minus_on_out(ym),
        .reference_route_out(route), .channel_invalid_out(inv), .touch_detect_interrupt_enable_out(pen),
        .converter_powered_out(pw), .word_valid_out(wv));
    function automatic logic [17:0] expect_of(input logic [15:0] r);
        return {r[14:0], ~(~r[9] & r[8]), ~r[8], r[9]};
    endfunction
    task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [31:0] b, input logic [5:0] n);
        @(negedge clock_in);
        bits = b;
        len = n;
        go = 1'b1;
        @(posedge done);
        go = 1'b0;
        repeat (6) @(negedge clock_in);
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict;
        end
    end
    initial begin
        repeat (3) @(negedge clock_in);
        arst_n_in = 1'b1;
        repeat (2) @(negedge clock_in);
        cmp(state, 18'h0300F);
        $display("reset test done");
        foreach (rows[i]) begin
            send({rows[i][15:8], 24'h0}, 6'h18);
            cmp(state, expect_of(rows[i]));
            $display("row %0d done", i);
        end
        prev = state;
        send(32'h0, 6'h20);
        cmp(state, prev);
        send({8'h96, 7'h7F, 17'h0}, 6'h20);
        cmp(state, expect_of(16'h9628));
        send({8'h9E, 3'h7, 21'h0}, 6'h20);
        cmp(state, expect_of(16'h9E28));
        send({8'h96, 7'h0, 8'hD3, 9'h0}, 6'h20);
        cmp(state, expect_of(16'hD354));
        send({8'h9E, 3'h0, 8'hE6, 13'h0}, 6'h20);
        cmp(state, expect_of(16'hE680));
        $display("spacing tests done");
        send({8'h98, 24'h0}, 6'h18);
        @(negedge clock_in);
        bits = {8'h98, 24'h0};
        go = 1'b1;
        repeat (3) @(negedge sclk);
        repeat (6) @(negedge clock_in);
        cmp({17'h0, pw}, 18'h0);
        @(negedge sclk);
        repeat (6) @(negedge clock_in);
        cmp({17'h0, pw}, 18'h1);
        @(posedge done);
        go = 1'b0;
        repeat (6) @(negedge clock_in);
        cmp({17'h0, pw}, 18'h0);
        $display("power test done");
        give_verdict;
    end
endmodule // testbench
`default_nettype wire
